//--- src/ddc_pkg.sv
// Constants, encodings and carriers of the DDR4 device-side timing block.
// Assumes a 25 MHz core clock and a link clock far slower than it.
package ddc_pkg;
   localparam int unsigned SYS_PERIOD_NS    = 40;
   localparam int unsigned CRC_ALERT_MIN_NS = 3;
   localparam int unsigned CRC_ALERT_MAX_NS = 13;
   localparam int unsigned ALERT_LAT_RU     =
      (CRC_ALERT_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int unsigned ALERT_LAT_CYC    =
      (ALERT_LAT_RU < 1) ? 1 : ALERT_LAT_RU;
   localparam int unsigned ALERT_PW_MIN_NCK = 6;
   localparam int unsigned ALERT_PW_MAX_NCK = 10;
   localparam logic [3:0]  ALERT_PW_NCK     = 4'h7;
   localparam logic [5:0]  WR_START_NCK     = 6'h04;
   localparam logic [5:0]  WR_START_BC4_NCK = 6'h02;
   localparam logic [19:0] TRFC1_NS         = 20'h00104;
   localparam logic [19:0] TRFC2_NS         = 20'h000A0;
   localparam logic [19:0] TRFC4_NS         = 20'h0006E;
   localparam logic [19:0] PS_PER_NS        = 20'h003E8;
   localparam logic [7:0]  REG_CTRL         = 8'h00;
   localparam logic [7:0]  REG_TCK          = 8'h04;
   localparam logic [7:0]  REG_FGR          = 8'h08;
   localparam logic [7:0]  REG_STAT         = 8'h0C;
   localparam logic [7:0]  REG_MASK         = 8'h10;
   localparam logic [7:0]  REG_STATE        = 8'h14;
   localparam int unsigned CTRL_WL_LSB      = 0;
   localparam int unsigned CTRL_BL_LSB      = 5;
   localparam int unsigned CTRL_DLL_BIT     = 7;
   localparam logic [7:0]  CTRL_RST         = 8'h09;
   localparam logic [15:0] TCK_RST          = 16'h04E2;
   localparam logic [1:0]  FGR_RST          = 2'h0;
   localparam int unsigned ST_CRC           = 0;
   localparam int unsigned ST_DLL           = 1;
   localparam int unsigned ST_WRS           = 2;
   localparam int unsigned ST_PD            = 3;
   localparam int unsigned ST_W             = 4;

   typedef enum logic [2:0] {
      CMD_DES, CMD_ACT, CMD_PRE, CMD_REF, CMD_WR, CMD_RD, CMD_ODT
   } ddc_cmd_t;
   typedef enum logic [1:0] {BL_FIX8, BL_OTF, BL_FIX4} ddc_bl_t;
   typedef enum logic [1:0] {FGR_1X, FGR_2X, FGR_4X} ddc_fgr_t;

   typedef struct packed {
      logic     cke;
      logic     bc4;
      ddc_cmd_t cmd;
   } ddc_pins_t;
endpackage : ddc_pkg

//--- src/ddc_timing.sv
// DDR4 device-side timing: CRC alert, internal write start, refresh and
// row-operation busy, power-down entry, DLL lock check, register port.
// Assumes link clock and pins are asynchronous; crc_err is core-clocked.
// What this block does
// - Alert goes active one core cycle after a write CRC error.
// - Alert stays active for 6 to 10 link clock cycles.
// - Internal write starts WL+4 clocks after write, WL+2 for fixed BC4.
// - Power-down takes effect only after running operations complete.
// - Nanosecond times become clock counts, rounded up.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module ddc_timing #(
   parameter logic [19:0] T_ROWOP_NS = 20'h0000F
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             ck_link,
   input  wire ddc_pkg::ddc_pins_t pins,
   input  wire logic             crc_err,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [31:0]      reg_rdata,
   output logic                  irq,
   output logic                  alert_n_o,
   output logic                  alert_n_oe,
   output logic                  wr_start,
   output logic                  pd_active
);
   // Synchronisers: first stage feeds only the second
   logic                ck_s1_r, ck_s2_r, ck_d_r;
   ddc_pkg::ddc_pins_t  pins_s1_r, pins_s2_r;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ck_s1_r   <= 1'b0;
         ck_s2_r   <= 1'b0;
         ck_d_r    <= 1'b0;
         pins_s1_r <= '0;
         pins_s2_r <= '0;
      end else begin
         ck_s1_r   <= ck_link;
         ck_s2_r   <= ck_s1_r;
         ck_d_r    <= ck_s2_r;
         pins_s1_r <= pins;
         pins_s2_r <= pins_s1_r;
      end
   end

   logic              ck_rise;
   ddc_pkg::ddc_cmd_t cmd;
   assign ck_rise = ck_s2_r & ~ck_d_r;
   assign cmd     = ck_rise ? pins_s2_r.cmd : ddc_pkg::CMD_DES;

   // Registers
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [15:0] tck_r, tck_nxt;
   logic [1:0]  fgr_r, fgr_nxt;
   logic [ddc_pkg::ST_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
   logic [31:0] rdata_nxt;
   logic        irq_nxt;
   logic [4:0]  wl;
   ddc_pkg::ddc_bl_t bl;
   logic        dll_lock;
   assign wl       = ctrl_r[ddc_pkg::CTRL_WL_LSB +: 5];
   assign bl       = ddc_pkg::ddc_bl_t'(ctrl_r[ddc_pkg::CTRL_BL_LSB +: 2]);
   assign dll_lock = ctrl_r[ddc_pkg::CTRL_DLL_BIT];

   // Alert pulse
   logic       alert_r, alert_nxt;
   logic [3:0] pw_r, pw_nxt;
   // Write start delay lines, one bit per link clock
   logic [39:0] line4_r, line4_nxt, line2_r, line2_nxt;
   logic        wrs_nxt, wr_now, fix4;
   logic [5:0]  off4, off2;
   // Busy tracking in picoseconds
   logic [19:0] acc_r, acc_nxt, tgt_r, tgt_nxt, trfc_ns;
   logic        busy;
   logic        pdreq_r, pdreq_nxt, pd_nxt, dll_viol;

   always_comb begin
      // Retrigger ignored while active so the pulse never exceeds its max
      alert_nxt = alert_r;
      pw_nxt    = pw_r;
      if (!alert_r && crc_err) begin
         alert_nxt = 1'b1;
         pw_nxt    = 4'h0;
      end else if (alert_r && ck_rise) begin
         pw_nxt = pw_r + 4'h1;
         if (pw_nxt == ddc_pkg::ALERT_PW_NCK) begin
            alert_nxt = 1'b0;
         end
      end
   end

   always_comb begin
      fix4      = (bl == ddc_pkg::BL_FIX4);
      wr_now    = (cmd == ddc_pkg::CMD_WR);
      off4      = {1'b0, wl} + ddc_pkg::WR_START_NCK;
      off2      = {1'b0, wl} + ddc_pkg::WR_START_BC4_NCK;
      line4_nxt = line4_r;
      line2_nxt = line2_r;
      if (ck_rise) begin
         line4_nxt = {line4_r[38:0], wr_now & ~fix4};
         line2_nxt = {line2_r[38:0], wr_now & fix4};
      end
      wrs_nxt = ck_rise & (line4_nxt[off4] | line2_nxt[off2]);
   end

   always_comb begin
      unique case (ddc_pkg::ddc_fgr_t'(fgr_r))
         ddc_pkg::FGR_2X: trfc_ns = ddc_pkg::TRFC2_NS;
         ddc_pkg::FGR_4X: trfc_ns = ddc_pkg::TRFC4_NS;
         default:         trfc_ns = ddc_pkg::TRFC1_NS;
      endcase
      busy    = (acc_r < tgt_r);
      acc_nxt = acc_r;
      tgt_nxt = tgt_r;
      // Whole link clocks until the sum reaches the time: a round-up
      if (cmd == ddc_pkg::CMD_ACT || cmd == ddc_pkg::CMD_PRE) begin
         acc_nxt = 20'h00000;
         tgt_nxt = 20'(T_ROWOP_NS * ddc_pkg::PS_PER_NS);
      end else if (cmd == ddc_pkg::CMD_REF) begin
         acc_nxt = 20'h00000;
         tgt_nxt = 20'(trfc_ns * ddc_pkg::PS_PER_NS);
      end else if (ck_rise && busy) begin
         acc_nxt = acc_r + {4'h0, tck_r};
      end
      pdreq_nxt = pdreq_r;
      if (ck_rise) begin
         pdreq_nxt = ~pins_s2_r.cke;
      end
      pd_nxt   = pdreq_r & ~busy;
      dll_viol = ~dll_lock & ((cmd == ddc_pkg::CMD_RD) ||
                 (cmd == ddc_pkg::CMD_ODT));
   end

   always_comb begin
      ctrl_nxt  = ctrl_r;
      tck_nxt   = tck_r;
      fgr_nxt   = fgr_r;
      mask_nxt  = mask_r;
      ev        = '0;
      ev[ddc_pkg::ST_CRC] = crc_err;
      ev[ddc_pkg::ST_DLL] = dll_viol;
      ev[ddc_pkg::ST_WRS] = wrs_nxt;
      ev[ddc_pkg::ST_PD]  = pd_nxt & ~pd_active;
      stat_nxt  = stat_r;
      if (reg_wr) begin
         unique case (reg_addr)
            ddc_pkg::REG_CTRL: ctrl_nxt = reg_wdata[7:0];
            ddc_pkg::REG_TCK:  tck_nxt  = reg_wdata[15:0];
            ddc_pkg::REG_FGR:  fgr_nxt  = reg_wdata[1:0];
            ddc_pkg::REG_STAT:
               stat_nxt = stat_r & ~reg_wdata[ddc_pkg::ST_W-1:0];
            ddc_pkg::REG_MASK: mask_nxt = reg_wdata[ddc_pkg::ST_W-1:0];
            default: ;
         endcase
      end
      // Set beats a clear in the same cycle
      stat_nxt  = stat_nxt | ev;
      irq_nxt   = |(stat_r & mask_r);
      rdata_nxt = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            ddc_pkg::REG_CTRL:  rdata_nxt = {24'h000000, ctrl_r};
            ddc_pkg::REG_TCK:   rdata_nxt = {16'h0000, tck_r};
            ddc_pkg::REG_FGR:   rdata_nxt = {30'h00000000, fgr_r};
            ddc_pkg::REG_STAT:  rdata_nxt = {28'h0000000, stat_r};
            ddc_pkg::REG_MASK:  rdata_nxt = {28'h0000000, mask_r};
            ddc_pkg::REG_STATE:
               rdata_nxt = {28'h0000000, pdreq_r, pd_active, busy, alert_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         alert_r   <= 1'b0;
         pw_r      <= 4'h0;
         line4_r   <= '0;
         line2_r   <= '0;
         wr_start  <= 1'b0;
         acc_r     <= 20'h00000;
         tgt_r     <= 20'h00000;
         pdreq_r   <= 1'b0;
         pd_active <= 1'b0;
         ctrl_r    <= ddc_pkg::CTRL_RST;
         tck_r     <= ddc_pkg::TCK_RST;
         fgr_r     <= ddc_pkg::FGR_RST;
         stat_r    <= '0;
         mask_r    <= '0;
         irq       <= 1'b0;
         reg_rdata <= 32'h0000_0000;
         alert_n_o  <= 1'b1;
         alert_n_oe <= 1'b0;
      end else begin
         alert_r   <= alert_nxt;
         pw_r      <= pw_nxt;
         line4_r   <= line4_nxt;
         line2_r   <= line2_nxt;
         wr_start  <= wrs_nxt;
         acc_r     <= acc_nxt;
         tgt_r     <= tgt_nxt;
         pdreq_r   <= pdreq_nxt;
         pd_active <= pd_nxt;
         ctrl_r    <= ctrl_nxt;
         tck_r     <= tck_nxt;
         fgr_r     <= fgr_nxt;
         stat_r    <= stat_nxt;
         mask_r    <= mask_nxt;
         irq       <= irq_nxt;
         reg_rdata <= rdata_nxt;
         // Open drain: only ever pulls low, shared line stays wired-AND
         alert_n_o  <= 1'b0;
         alert_n_oe <= alert_nxt;
      end
   end

   // Helper: link edges seen while the alert is driven
   logic [4:0] h_edges_r;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         h_edges_r <= 5'h00;
      end else if (!alert_n_oe) begin
         h_edges_r <= 5'h00;
      end else if (ck_rise && h_edges_r != 5'h1F) begin
         h_edges_r <= h_edges_r + 5'h01;
      end
   end

   sequence s_err_idle;
      crc_err && !alert_r;
   endsequence
   sequence s_drive;
      alert_n_oe && !alert_n_o;
   endsequence

   property p_alert_lat;
      @(posedge clock) disable iff (!nrst) s_err_idle |=> s_drive;
   endproperty
   a_alert_lat: assert property (p_alert_lat)
      else $error("alert not driven one cycle after crc error");

   property p_alert_pw;
      @(posedge clock) disable iff (!nrst)
         $fell(alert_n_oe) |-> (h_edges_r >= 5'h06 && h_edges_r <= 5'h0A);
   endproperty
   a_alert_pw: assert property (p_alert_pw)
      else $error("alert pulse width out of range");

   property p_alert_low;
      @(posedge clock) disable iff (!nrst) alert_n_oe |-> !alert_n_o;
   endproperty
   a_alert_low: assert property (p_alert_low)
      else $error("alert driven high");

   property p_wrs_only_edge;
      @(posedge clock) disable iff (!nrst) wr_start |-> $past(ck_rise);
   endproperty
   a_wrs_only_edge: assert property (p_wrs_only_edge)
      else $error("write start away from link edge");

   property p_wrs_bl8;
      @(posedge clock) disable iff (!nrst)
         (ck_rise && wl == 5'h09 && bl == ddc_pkg::BL_FIX8 &&
          line4_r[12]) |=> wr_start;
   endproperty
   a_wrs_bl8: assert property (p_wrs_bl8)
      else $error("write start not at WL+4");

   property p_pd_busy;
      @(posedge clock) disable iff (!nrst) pd_active |-> $past(!busy);
   endproperty
   a_pd_busy: assert property (p_pd_busy)
      else $error("power-down while operation running");

   property p_pd_entry;
      @(posedge clock) disable iff (!nrst)
         (pdreq_r && !busy) |=> pd_active;
   endproperty
   a_pd_entry: assert property (p_pd_entry)
      else $error("power-down not entered when idle");

   property p_ref_busy;
      @(posedge clock) disable iff (!nrst)
         (cmd == ddc_pkg::CMD_REF && tck_r != 16'h0000) |=> busy;
   endproperty
   a_ref_busy: assert property (p_ref_busy)
      else $error("refresh did not start busy window");

   property p_ru_end;
      @(posedge clock) disable iff (!nrst)
         $fell(busy) && $past(ck_rise) |->
            (acc_r >= tgt_r) && ($past(acc_r) < tgt_r);
   endproperty
   a_ru_end: assert property (p_ru_end)
      else $error("busy window not rounded up");

   property p_dll;
      @(posedge clock) disable iff (!nrst)
         dll_viol |=> stat_r[ddc_pkg::ST_DLL];
   endproperty
   a_dll: assert property (p_dll)
      else $error("read without dll lock not flagged");
endmodule : ddc_timing

//--- dv/ddc_ctrl_model.sv
// Controller-side model: link clock and command pins.
// Assumes the device takes its pins at link clock rises.
`timescale 1ns/1ps
module ddc_ctrl_model #(
   parameter int HALF_NS = 160
) (
   output logic               ck_link,
   output ddc_pkg::ddc_pins_t pins
);
   initial begin
      ck_link = 1'b0;
      pins    = '{cke: 1'b1, bc4: 1'b0, cmd: ddc_pkg::CMD_DES};
   end
   // Free running, the device input clock never stops here
   always #(HALF_NS) ck_link = ~ck_link;
   // Nanoseconds to whole clocks, any fraction rounds up
   function automatic int ru_div(input int num, input int den);
      return (num + den - 1) / den;
   endfunction : ru_div
   // No mode register sets: gear-down, MPR and CRC-mask spacings
   // never arise in this traffic
   // Refreshes few and far apart, inside the cold-range interval
   // Pins move at link falls: settled for half a period each side
   // Any spacing allowed; cke may drop mid-refresh
   task automatic issue(input logic cke, input logic bc4,
                        input ddc_pkg::ddc_cmd_t cmd);
      @(negedge ck_link);
      pins <= '{cke: cke, bc4: bc4, cmd: cmd};
      @(negedge ck_link);
      // Deselect right after every command, so any alert is answered
      pins <= '{cke: cke, bc4: 1'b0, cmd: ddc_pkg::CMD_DES};
   endtask : issue
endmodule : ddc_ctrl_model

//--- dv/ddc_timing_tb.sv
// Testbench of the device-side timing block.
// Assumes the controller model drives link clock and command pins.
`timescale 1ns/1ps
module ddc_timing_tb;
   logic               clock, nrst, crc_err, reg_wr, reg_rd;
   logic               irq, alert_n_o, alert_n_oe, wr_start, pd_active;
   logic               ck_link;
   logic [7:0]         reg_addr;
   logic [31:0]        reg_wdata, reg_rdata, rv;
   ddc_pkg::ddc_pins_t pins;
   int                 err_total, num_checks, cycles, rises, base, n;
   int                 tns [5] = '{260, 160, 110, 15, 15};
   logic [31:0]        rst_tab [7] = '{32'h09, 32'h04E2, 32'h0, 32'h0,
                                       32'h0, 32'h0, 32'h0};
   // Pull-up on the shared alert line when released
   wire                alert_wire = alert_n_oe ? alert_n_o : 1'b1;

   ddc_timing #(.T_ROWOP_NS(20'h0000F)) ddc_timing_i (
      .clock(clock), .nrst(nrst), .ck_link(ck_link), .pins(pins),
      .crc_err(crc_err), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
      .wr_start(wr_start), .pd_active(pd_active));
   ddc_ctrl_model ddc_ctrl_model_i (.ck_link(ck_link), .pins(pins));

   always #20 clock = ~clock;
   always @(posedge ck_link) rises <= rises + 1;
   // Whole run needs about 4200 cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : wr

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   initial begin
      clock = 0; nrst = 0; crc_err = 0; reg_wr = 0; reg_rd = 0;
      reg_addr = '0; reg_wdata = '0; rv = '0;
      err_total = 0; num_checks = 0; cycles = 0; rises = 0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      #1 check(alert_wire, 1'b1);
      wr(8'h18, 32'hFFFFFFFF);
      for (int i = 0; i < 7; i++) begin
         rd(8'(i * 4), rv);
         check(rv, rst_tab[i]);
      end
      // Error with interrupt masked off first
      @(posedge clock);
      crc_err <= 1'b1;
      @(posedge clock);
      crc_err <= 1'b0;
      #1 check(alert_n_oe, 1'b1);
      check(alert_wire, 1'b0);
      base = rises;
      for (int i = 0; i < 600 && alert_n_oe === 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      n = rises - base;
      check(32'(n >= 6 && n <= 10), 32'h1);
      check(irq, 1'b0);
      wr(8'h10, 32'h1);
      repeat (2) @(posedge clock);
      #1 check(irq, 1'b1);
      rd(8'h0C, rv);
      check(rv, 32'h1);
      wr(8'h0C, 32'h1);
      repeat (2) @(posedge clock);
      #1 check(irq, 1'b0);
      // Fixed BL8, on-the-fly chop, fixed chop
      for (int m = 0; m < 3; m++) begin
         wr(8'h00, 32'(m * 32 + 9));
         ddc_ctrl_model_i.issue(1'b1, m == 1, ddc_pkg::CMD_WR);
         base = rises;
         for (int i = 0; i < 600 && wr_start !== 1'b1; i++) begin
            @(posedge clock);
            #1;
         end
         check(32'(rises - base), (m == 2) ? 32'h0B : 32'h0D);
      end
      // Read and ODT, DLL unlocked then locked
      for (int k = 0; k < 4; k++) begin
         wr(8'h00, k[1] ? 32'h89 : 32'h09);
         wr(8'h0C, 32'h0F);
         ddc_ctrl_model_i.issue(1'b1, 1'b0,
            k[0] ? ddc_pkg::CMD_ODT : ddc_pkg::CMD_RD);
         rd(8'h0C, rv);
         check(rv & 32'h2, k[1] ? 32'h0 : 32'h2);
      end
      // Refresh 1x, 2x, 4x, activate, precharge; cke dropped meanwhile
      for (int j = 0; j < 5; j++) begin
         wr(8'h08, 32'(j % 3));
         ddc_ctrl_model_i.issue(1'b1, 1'b0, (j == 4) ? ddc_pkg::CMD_PRE :
            (j == 3) ? ddc_pkg::CMD_ACT : ddc_pkg::CMD_REF);
         base = rises;
         ddc_ctrl_model_i.issue(1'b0, 1'b0, ddc_pkg::CMD_DES);
         check(pd_active, 1'b0);
         // Request pending, still busy, not yet in power-down
         rd(8'h14, rv);
         check(rv, 32'hA);
         for (int i = 0; i < 3000 && pd_active !== 1'b1; i++) begin
            @(posedge clock);
            #1;
         end
         // Busy rises: ns over the 1250 ps period, rounded up
         n = rises - base - ddc_ctrl_model_i.ru_div(tns[j] * 1000, 1250);
         check(32'(n >= 0 && n <= 1), 32'h1);
         ddc_ctrl_model_i.issue(1'b1, 1'b0, ddc_pkg::CMD_DES);
         check(pd_active, 1'b0);
      end
      give_verdict();
   end
endmodule : ddc_timing_tb
